// ===== shdp_pkg.sv
/*
  Shared constants for the user data port: word and counter widths,
  buffer depth and the free-space margin on the receive side.
  Assumes nothing of its surroundings.
*/
package shdp_pkg;
  localparam int          SHDP_WORD_W      = 128;
  localparam int          SHDP_CNT_W       = 16;
  localparam int          SHDP_BUF_DEPTH   = 8;
  // free words the receive FIFO must show before a push; covers count latency
  localparam logic [15:0] SHDP_RX_MARGIN   = 16'h0004;
  localparam logic [15:0] SHDP_CNT_ALL_ONE = 16'hFFFF;
  localparam logic [15:0] SHDP_CNT_ZERO    = 16'h0000;
endpackage

// ===== shdp_stream_if.sv
/*
  Valid/ready word stream used between the data port and its buffers.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ns
interface shdp_stream_if #(
  parameter int WIDTH = 128
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ===== shdp_buf.sv
/*
  Small synchronous FIFO with valid/ready on both sides and a level output.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ns
module shdp_buf #(
  parameter int WIDTH = 128,
  parameter int DEPTH = 8
) (
  input  wire logic                     clk_sys,
  input  wire logic                     reset_n,
  shdp_stream_if.snk                    fill,
  shdp_stream_if.src                    drain,
  output logic [$clog2(DEPTH):0]        level
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("buffer depth must be a power of two, at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             do_wr;
  logic             do_rd;

  ////////////////////////////////////////////////////////////////////////////
  assign level       = wr_ptr - rd_ptr;
  assign fill.ready  = (level != DEPTH[AW:0]) ? 1'b1 : 1'b0;
  assign drain.valid = (level != '0) ? 1'b1 : 1'b0;
  assign drain.data  = mem[rd_ptr[AW-1:0]];
  assign do_wr       = fill.valid & fill.ready;
  assign do_rd       = drain.valid & drain.ready;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= fill.data;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
    end else if (do_wr) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_ptr <= '0;
    end else if (do_rd) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

// ===== shdp_data_port.sv
/*
  User data port of the storage host controller: moves words from the
  controller's read-data stream into the user receive FIFO, and from the
  user transmit FIFO into the controller's write-data stream, each through
  an internal buffer.
  Assumes user FIFOs on the same clock, counters updating one cycle after
  a push or pop, and the user transmit FIFO returning data one cycle late.
*/
// Notes on behaviour
// - receive write counter input decides whether more data may be pushed.
// - transmit read counter input gives the number of stored words.
// - push strobe high each cycle a word enters the receive FIFO, Read only.
// - 128-bit push word valid only while push strobe is high.
// - transmit empty flag input is ignored entirely.
// - pop strobe high each cycle a word leaves the transmit FIFO, Write only.
`timescale 1ns/1ns
module shdp_data_port
  import shdp_pkg::*;
#(
  parameter int          BUF_DEPTH = shdp_pkg::SHDP_BUF_DEPTH,
  parameter logic [15:0] RX_MARGIN = shdp_pkg::SHDP_RX_MARGIN
) (
  input  wire logic                               clk_sys,
  input  wire logic                               reset_n,
  input  wire logic                               read_cmd_active,
  input  wire logic                               write_cmd_active,
  input  wire logic                               ssd_rd_valid,
  input  wire logic [shdp_pkg::SHDP_WORD_W-1:0]   ssd_rd_word,
  output logic                                    ssd_rd_ready,
  output logic                                    ssd_wr_valid,
  output logic [shdp_pkg::SHDP_WORD_W-1:0]        ssd_wr_word,
  input  wire logic                               ssd_wr_ready,
  input  wire logic [shdp_pkg::SHDP_CNT_W-1:0]    rx_fifo_fill_count,
  output logic                                    rx_fifo_push,
  output logic [shdp_pkg::SHDP_WORD_W-1:0]        rx_fifo_push_word,
  input  wire logic [shdp_pkg::SHDP_CNT_W-1:0]    tx_fifo_stored_count,
  input  wire logic                               tx_fifo_empty_flag,
  output logic                                    tx_fifo_pop,
  input  wire logic [shdp_pkg::SHDP_WORD_W-1:0]   tx_fifo_pop_word
);
  import shdp_pkg::*;

  localparam int LW = $clog2(BUF_DEPTH) + 1;

  generate
    if (RX_MARGIN < 16'h0002) begin : g_bad_margin
      $error("receive margin must cover the registered push in flight");
    end
    if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("buffer depth must be a power of two, at least 2");
    end
    if (SHDP_CNT_W != 16) begin : g_bad_count
      $error("user FIFO counters are taken as 16 bits wide");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // free slots as the user FIFO reports them; unused upper bits read as one
  function automatic logic [15:0] free_slots(
    input logic [15:0] fill_count
  );
    return SHDP_CNT_ALL_ONE - fill_count;
  endfunction

  // the stored count still holds a word once the pop in flight is set aside
  function automatic logic words_left(
    input logic [15:0] stored_count,
    input logic        in_flight
  );
    return (stored_count > {15'h0000, in_flight}) ? 1'b1 : 1'b0;
  endfunction

  // buffer keeps a slot free after the word already on its way lands
  function automatic logic has_room(
    input logic [LW-1:0] level,
    input logic          in_flight
  );
    return ((level + {{(LW-1){1'b0}}, in_flight}) < BUF_DEPTH[LW-1:0]) ? 1'b1 : 1'b0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // strobes are held off until the first edge after reset; the pop is
  // combinational and a word popped during reset would have nowhere to land
  logic port_live;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      port_live <= 1'b0;
    end else begin
      port_live <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive path: controller read data -> buffer -> user receive FIFO

  shdp_stream_if #(.WIDTH(SHDP_WORD_W)) rx_in ();
  shdp_stream_if #(.WIDTH(SHDP_WORD_W)) rx_out ();
  logic [15:0]   rx_free;
  logic          rx_room_ok;
  logic          rx_take;

  assign rx_in.valid  = ssd_rd_valid;
  assign rx_in.data   = ssd_rd_word;
  assign ssd_rd_ready = rx_in.ready;

  shdp_buf #(.WIDTH(SHDP_WORD_W), .DEPTH(BUF_DEPTH)) u_rx_buf (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .fill    (rx_in),
    .drain   (rx_out),
    .level   ()
  );

  // upper bits tied high by the user make the free count the real one;
  // the margin covers the push in flight that the count has not yet seen
  assign rx_free      = free_slots(rx_fifo_fill_count);
  assign rx_room_ok   = (rx_free >= RX_MARGIN) ? 1'b1 : 1'b0;
  assign rx_take      = port_live & read_cmd_active & rx_out.valid & rx_room_ok;
  assign rx_out.ready = rx_take;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rx_fifo_push <= 1'b0;
    end else begin
      rx_fifo_push <= rx_take;
    end
  end

  // word only changes with a push, so it is stable outside the strobe
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rx_fifo_push_word <= '0;
    end else if (rx_take) begin
      rx_fifo_push_word <= rx_out.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit path: user transmit FIFO -> buffer -> controller write data

  shdp_stream_if #(.WIDTH(SHDP_WORD_W)) tx_in ();
  shdp_stream_if #(.WIDTH(SHDP_WORD_W)) tx_out ();
  logic [LW-1:0] tx_level;
  logic          pop_pending;
  logic          tx_src_ok;
  logic          tx_room_ok;
  logic          pop_ok;

  // counter may lag a pop by one cycle, so the pop in flight is set aside;
  // with a prompt counter this costs at most one idle cycle on the last word
  assign tx_src_ok   = words_left(tx_fifo_stored_count, pop_pending);
  assign tx_room_ok  = has_room(tx_level, pop_pending);
  assign pop_ok      = port_live & write_cmd_active & tx_src_ok & tx_room_ok;
  assign tx_fifo_pop = pop_ok;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pop_pending <= 1'b0;
    end else begin
      pop_pending <= pop_ok;
    end
  end

  // popped word arrives the cycle after the strobe; room was reserved then
  assign tx_in.valid = pop_pending;
  assign tx_in.data  = tx_fifo_pop_word;

  shdp_buf #(.WIDTH(SHDP_WORD_W), .DEPTH(BUF_DEPTH)) u_tx_buf (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .fill    (tx_in),
    .drain   (tx_out),
    .level   (tx_level)
  );

  assign ssd_wr_valid = tx_out.valid;
  assign ssd_wr_word  = tx_out.data;
  assign tx_out.ready = ssd_wr_ready;

  // tx_fifo_empty_flag is deliberately left unread; the count is authoritative
endmodule

// ===== shdp_port_sva.sv
/* Checker on the data port pins.
   Assumes one clock and the bind below. */
`timescale 1ns/1ns
module shdp_port_sva
  import shdp_pkg::*;
#(parameter logic [15:0] RX_MARGIN = shdp_pkg::SHDP_RX_MARGIN) (
  input wire logic         clk_sys,
  input wire logic         reset_n,
  input wire logic         read_cmd_active,
  input wire logic         write_cmd_active,
  input wire logic         ssd_rd_ready,
  input wire logic         ssd_wr_valid,
  input wire logic [15:0]  rx_fifo_fill_count,
  input wire logic         rx_fifo_push,
  input wire logic [127:0] rx_fifo_push_word,
  input wire logic [15:0]  tx_fifo_stored_count,
  input wire logic         tx_fifo_pop
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////
  push_gate_a: assert property (rx_fifo_push |-> $past(read_cmd_active)) else $error("push outside read");
  rx_room_a: assert property (
    rx_fifo_push |-> SHDP_CNT_ALL_ONE - $past(rx_fifo_fill_count) >= RX_MARGIN) else $error("push without room");
  rx_live_a: assert property (
    !ssd_rd_ready && read_cmd_active && SHDP_CNT_ALL_ONE - rx_fifo_fill_count >= RX_MARGIN |=> rx_fifo_push)
    else $error("room but no push");
  word_hold_a: assert property ($changed(rx_fifo_push_word) |-> rx_fifo_push) else $error("word moved");
  pop_gate_a: assert property (tx_fifo_pop |-> write_cmd_active) else $error("pop outside write");
  pop_count_a: assert property (
    tx_fifo_pop |-> tx_fifo_stored_count > 16'($past(tx_fifo_pop))) else $error("pop past count");
  pop_land_a: assert property (tx_fifo_pop |-> ##2 ssd_wr_valid) else $error("popped word lost");
  cover property (rx_fifo_push ##1 rx_fifo_push);
  cover property (tx_fifo_pop ##1 tx_fifo_pop);
  cover property (!ssd_rd_ready && read_cmd_active);
endmodule
bind shdp_data_port shdp_port_sva #(.RX_MARGIN(RX_MARGIN)) u_shdp_port_sva (
  .clk_sys              (clk_sys),
  .reset_n              (reset_n),
  .read_cmd_active      (read_cmd_active),
  .write_cmd_active     (write_cmd_active),
  .ssd_rd_ready         (ssd_rd_ready),
  .ssd_wr_valid         (ssd_wr_valid),
  .rx_fifo_fill_count   (rx_fifo_fill_count),
  .rx_fifo_push         (rx_fifo_push),
  .rx_fifo_push_word    (rx_fifo_push_word),
  .tx_fifo_stored_count (tx_fifo_stored_count),
  .tx_fifo_pop          (tx_fifo_pop)
);

// ===== shdp_fifo_model.sv
/* User receive and transmit FIFO model.
   Bench fills tx_q and drives rx_drain; same clock as the port. */
`timescale 1ns/1ns
module shdp_fifo_model (
  input  wire logic    clk_sys,
  input  wire logic    reset_n,
  input  wire logic    rx_drain,
  input  wire logic    rx_fifo_push,
  output logic [15:0]  rx_fifo_fill_count,
  input  wire logic    tx_fifo_pop,
  output logic [15:0]  tx_fifo_stored_count = 16'h0000,
  output logic [127:0] tx_fifo_pop_word = 128'h0
);
  logic [3:0]   rx_lvl;
  logic [127:0] tx_q[$];
  // receive level holds at most 15 words, only four counter bits
  assign rx_fifo_fill_count = {12'hFFF, rx_lvl};
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) rx_lvl <= 4'h0;
    else rx_lvl <= rx_lvl + 4'(rx_fifo_push) - 4'(rx_drain && rx_lvl != 4'h0);
  end
  always @(posedge clk_sys) begin
    if (tx_fifo_pop && tx_q.size() != 0) tx_fifo_pop_word <= tx_q.pop_front();
    else tx_fifo_pop_word <= ~tx_fifo_pop_word; // stale data not held
    tx_fifo_stored_count <= {4'h0, 12'(tx_q.size())};
  end
endmodule

// ===== tb_top.sv
/* Random traffic both ways through the data port.
   Assumes the user FIFO model; seed fixed. */
`timescale 1ns/1ns
module tb_top;
`define CHK(n, e, s) begin exp_v = (e); n_tests++; if (exp_v !== (s)) begin fail_count++; \
  $display("[FAIL] %s exp %0h got %0h", n, exp_v, s); end end
  logic         clk_sys, reset_n, read_cmd_active, write_cmd_active, ssd_rd_valid, ssd_rd_ready, ssd_wr_valid;
  logic         ssd_wr_ready, rx_fifo_push, tx_fifo_pop, tx_fifo_empty_flag, rx_drain;
  logic [127:0] ssd_rd_word, ssd_wr_word, rx_fifo_push_word, tx_fifo_pop_word, exp_v;
  logic [15:0]  rx_fifo_fill_count, tx_fifo_stored_count;
  logic [127:0] rx_exp[$], tx_exp[$];
  int           seed = 23, fail_count = 0, n_tests = 0, i = 0, j;
  shdp_data_port u_shdp_data_port (
    .clk_sys (clk_sys), .reset_n (reset_n), .read_cmd_active (read_cmd_active),
    .write_cmd_active (write_cmd_active), .ssd_rd_valid (ssd_rd_valid), .ssd_rd_word (ssd_rd_word),
    .ssd_rd_ready (ssd_rd_ready), .ssd_wr_valid (ssd_wr_valid), .ssd_wr_word (ssd_wr_word),
    .ssd_wr_ready (ssd_wr_ready), .rx_fifo_fill_count (rx_fifo_fill_count), .rx_fifo_push (rx_fifo_push),
    .rx_fifo_push_word (rx_fifo_push_word), .tx_fifo_stored_count (tx_fifo_stored_count),
    .tx_fifo_empty_flag (tx_fifo_empty_flag), .tx_fifo_pop (tx_fifo_pop), .tx_fifo_pop_word (tx_fifo_pop_word));
  shdp_fifo_model u_shdp_fifo_model (
    .clk_sys (clk_sys), .reset_n (reset_n), .rx_drain (rx_drain), .rx_fifo_push (rx_fifo_push),
    .rx_fifo_fill_count (rx_fifo_fill_count), .tx_fifo_pop (tx_fifo_pop),
    .tx_fifo_stored_count (tx_fifo_stored_count), .tx_fifo_pop_word (tx_fifo_pop_word));
  function automatic logic [127:0] rnd();
    return {$random(seed), $random(seed), $random(seed), $random(seed)};
  endfunction
  task complete_run;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #100000 fail_count++;
    complete_run;
  end
  // first 20 words land with the receive side stalled, so it fills to the margin
  always @(negedge clk_sys) begin
    read_cmd_active = |($random(seed) & 7);
    write_cmd_active = |($random(seed) & 7);
    ssd_wr_ready = 1'($random(seed));
    tx_fifo_empty_flag = 1'($random(seed));
    rx_drain = i >= 20 && 1'($random(seed));
  end
  always @(posedge clk_sys) begin
    if (rx_fifo_push) `CHK("rx_word", rx_exp.pop_front(), rx_fifo_push_word)
    if (ssd_wr_valid && ssd_wr_ready) `CHK("tx_word", tx_exp.pop_front(), ssd_wr_word)
    if (rx_fifo_push) `CHK("push_room", 128'h1, 128'(rx_fifo_fill_count != 16'hFFFF))
    if (tx_fifo_pop) `CHK("pop_stock", 128'h1, 128'(tx_fifo_stored_count != 16'h0000))
  end
  initial begin
    reset_n = 0; ssd_rd_valid = 0; ssd_rd_word = '0; ssd_wr_ready = 0; read_cmd_active = 0;
    write_cmd_active = 0; tx_fifo_empty_flag = 0; rx_drain = 0;
    for (j = 0; j < 40; j++) begin
      tx_exp.push_back(rnd());
      u_shdp_fifo_model.tx_q.push_back(tx_exp[j]);
    end
    repeat (20) @(negedge clk_sys);
    reset_n = 1;
    for (i = 0; i < 48; i++) begin
      ssd_rd_word = rnd();
      ssd_rd_valid = 1;
      rx_exp.push_back(ssd_rd_word);
      while (!ssd_rd_ready) @(negedge clk_sys);
      @(negedge clk_sys);
      if ($random(seed) & 1) begin
        ssd_rd_valid = 0;
        @(negedge clk_sys);
      end
    end
    ssd_rd_valid = 0;
    for (j = 0; j < 3000 && rx_exp.size() + tx_exp.size() != 0; j++) @(negedge clk_sys);
    `CHK("rx_left", 128'h0, 128'(rx_exp.size()))
    `CHK("tx_left", 128'h0, 128'(tx_exp.size()))
    complete_run;
  end
endmodule
